//--- core/pwt_pkg.sv
package pwt_pkg;

  // ==========================================================
  // Bus geometry
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;

  // ==========================================================
  // Register offsets
  localparam logic [3:0] OFF_STATUS_CONTROL = 4'h0;
  localparam logic [3:0] OFF_IRQ_STATUS = 4'h1;
  localparam logic [3:0] OFF_IRQ_MASK = 4'h2;
  localparam logic [3:0] OFF_COUNT_LO = 4'h3;
  localparam logic [3:0] OFF_COUNT_HI = 4'h4;

  // ==========================================================
  // Status and control field positions
  localparam int unsigned BIT_TIMEOUT_FLAG = 7;
  localparam int unsigned BIT_FLAG_CLEAR = 6;
  localparam int unsigned BIT_CLOCK_SELECT = 5;
  localparam int unsigned BIT_IRQ_ENABLE = 4;
  localparam int unsigned PSEL_MSB = 2;
  localparam int unsigned PSEL_LSB = 0;

  // Interrupt status and mask field positions
  localparam int unsigned EVT_TIMEOUT = 0;
  localparam int unsigned EVT_OVERRUN = 1;
  localparam int unsigned EVT_W = 2;

  // ==========================================================
  // Reset values
  localparam logic RST_CLOCK_SELECT = 1'b0;
  localparam logic RST_IRQ_ENABLE = 1'b0;
  localparam logic [2:0] RST_PERIOD_SELECT = 3'h0;
  localparam logic [1:0] RST_IRQ_MASK = 2'h0;

  // ==========================================================
  // Timing
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned OSC_PERIOD_MS = 1;
  localparam int unsigned OSC_CYCLES = (OSC_PERIOD_MS * 1000000) / CLK_PERIOD_NS;

  // Internal source: periods in oscillator ticks for codes 0..7
  localparam logic [15:0] INT_TICKS [8] = '{16'h0000, 16'h0008, 16'h0020, 16'h0040,
                                            16'h0080, 16'h0100, 16'h0200, 16'h0400};
  // External source: divisors for codes 0 and 2..7; code 1 takes EXT_DIV_CODE1 instead
  localparam logic [15:0] EXT_DIVS [8] = '{16'h0000, 16'h0000, 16'h0400, 16'h0800,
                                           16'h1000, 16'h2000, 16'h4000, 16'h8000};
  localparam logic [15:0] EXT_DIV_CODE1 = 16'h0100;

  // ==========================================================
  // Counter control states
  typedef enum logic [2:0] {
    PWT_ST_OFF = 3'b001,
    PWT_ST_LOAD = 3'b010,
    PWT_ST_RUN = 3'b100
  } pwt_state_t;

endpackage

//--- core/pwt_osc.sv
`timescale 1ns/1ns
module pwt_osc #(
  parameter int unsigned OSC_CYCLES = pwt_pkg::OSC_CYCLES
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Control and tick
  input wire logic run_in,
  output logic tick_out
);
  import pwt_pkg::*;

  logic [23:0] div_r;

  // ==========================================================
  // 1 ms reference counted on clk_in, cleared and held while run_in is low
  // Restart keeps the first tick a full period after run
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      div_r <= 24'h000000;
    end else if (!run_in || div_r == 24'(OSC_CYCLES - 1)) begin
      div_r <= 24'h000000;
    end else begin
      div_r <= div_r + 24'h000001;
    end
  end

  // One-cycle tick at the end of each reference period
  assign tick_out = run_in && (div_r == 24'(OSC_CYCLES - 1));

endmodule

//--- core/pwt_top.sv
`timescale 1ns/1ns
module pwt_top
  import pwt_pkg::*;
#(
  parameter int unsigned OSC_CYCLES = pwt_pkg::OSC_CYCLES
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic arst_n_in,
  // External timer source, synchronous to clk_in
  input wire logic ext_clk_in,
  // Register port
  input wire logic [pwt_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic [pwt_pkg::DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [pwt_pkg::DATA_W-1:0] reg_rdata_out,
  // Requests
  output logic wakeup_irq_out,
  output logic irq_out
);
  import pwt_pkg::*;

  // Datapath in brief: a source tick, either the 1 ms reference or an
  // external rising edge, advances the period counter while the control
  // sits in RUN; the tick that meets the terminal count is the timeout,
  // which sets the flag and the timeout event on the same edge.

  // ==========================================================
  // Declarations
  // Reset copies
  logic rst_meta_r;
  logic rst_sync_r;
  logic rst_n;

  // Register fields
  logic wakeup_timeout_flag_r;
  logic wakeup_clock_select_r;
  logic wakeup_irq_enable_r;
  logic [2:0] wakeup_period_select_r;
  logic [EVT_W-1:0] irq_status_r;
  logic [EVT_W-1:0] irq_mask_r;

  // Read path
  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] rdata_nxt;

  // Timing sources
  logic ext_prev_r;
  logic ext_rise;
  logic osc_tick;
  logic osc_run;
  logic src_tick;

  // Period counter
  logic [15:0] count_r;
  logic [15:0] count_hold_r;
  logic [15:0] terminal;
  logic timeout;

  // Bus decode and events
  logic cfg_change;
  logic wr_ctrl;
  logic rd_irq;
  logic flag_clear;
  logic [EVT_W-1:0] evt;

  // Counter control
  pwt_state_t state_r;
  pwt_state_t state_nxt;

  // ==========================================================
  // Reset release
  // Asserts at once, releases two edges after the pin goes high
  // All other flops reset from rst_n, so they all leave reset on one edge
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  assign rst_n = rst_sync_r;

  // ==========================================================
  // Register access decode
  // Unmapped offsets neither write nor read anything
  assign wr_ctrl = reg_wr_in && (reg_addr_in == OFF_STATUS_CONTROL);
  assign rd_irq = reg_rd_in && (reg_addr_in == OFF_IRQ_STATUS);

  assign flag_clear = wr_ctrl && reg_wdata_in[BIT_FLAG_CLEAR];

  // A reconfiguration restarts the count so a new period is never cut short
  assign cfg_change = wr_ctrl &&
                      ((reg_wdata_in[BIT_CLOCK_SELECT] != wakeup_clock_select_r) ||
                       (reg_wdata_in[PSEL_MSB:PSEL_LSB] != wakeup_period_select_r));

  // ==========================================================
  // Control fields
  // Bit 7 is read-only and bit 6 only a strobe, so neither is stored here
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      wakeup_clock_select_r <= RST_CLOCK_SELECT;
      wakeup_irq_enable_r <= RST_IRQ_ENABLE;
      wakeup_period_select_r <= RST_PERIOD_SELECT;
    end else if (wr_ctrl) begin
      wakeup_clock_select_r <= reg_wdata_in[BIT_CLOCK_SELECT];
      wakeup_irq_enable_r <= reg_wdata_in[BIT_IRQ_ENABLE];
      // bit 3 and bit 7 writes dropped
      wakeup_period_select_r <= reg_wdata_in[PSEL_MSB:PSEL_LSB];
    end
  end

  // ==========================================================
  // Interrupt mask
  // Masking gates irq_out only; status bits still collect events
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      irq_mask_r <= RST_IRQ_MASK;
    end else if (reg_wr_in && (reg_addr_in == OFF_IRQ_MASK)) begin
      irq_mask_r <= reg_wdata_in[EVT_W-1:0];
    end
  end

  // ==========================================================
  // Timing sources
  // 1 ms reference from the block clock
  // Dropped for the reconfiguration cycle, so a new period starts on a fresh reference
  assign osc_run = (state_r != PWT_ST_OFF) && !wakeup_clock_select_r &&
                   !cfg_change;

  pwt_osc #(
    .OSC_CYCLES(OSC_CYCLES)
  ) u_osc (
    .clk_in(clk_in),
    .rst_n_in(rst_n),
    .run_in(osc_run),
    .tick_out(osc_tick)
  );

  // External source is taken as synchronous; one flop finds its rising edge
  // Limitation: each level must last at least one clk_in cycle or edges are lost
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      ext_prev_r <= 1'b0;
    end else begin
      ext_prev_r <= ext_clk_in;
    end
  end

  assign ext_rise = ext_clk_in && !ext_prev_r;

  // Switching source passes through LOAD, so no stale tick is counted
  // source multiplexer
  assign src_tick = wakeup_clock_select_r ? ext_rise : osc_tick;

  // ==========================================================
  // Period lookup
  // Code 0 gives a zero terminal, which the control never lets the counter use
  always_comb begin
    if (wakeup_clock_select_r) begin
      terminal = (wakeup_period_select_r == 3'h1) ? EXT_DIV_CODE1 : EXT_DIVS[wakeup_period_select_r];
    end else begin
      terminal = INT_TICKS[wakeup_period_select_r];
    end
  end

  // ==========================================================
  // Counter control
  // LOAD holds the count at zero for one cycle so each period starts clean
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      PWT_ST_OFF: begin
        if (wakeup_period_select_r != 3'h0) begin
          state_nxt = PWT_ST_LOAD;
        end
      end
      PWT_ST_LOAD: begin
        state_nxt = PWT_ST_RUN;
      end
      PWT_ST_RUN: begin
        if (cfg_change) begin
          state_nxt = PWT_ST_LOAD;
        end
      end
      default: begin
        state_nxt = PWT_ST_OFF;
      end
    endcase
    if (wakeup_period_select_r == 3'h0) begin
      state_nxt = PWT_ST_OFF;
    end
  end

  // One-hot register; an illegal code falls back to OFF
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= PWT_ST_OFF;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ==========================================================
  // Period counter
  // Counts source ticks; the last tick of a period is the timeout
  // Trade-off: a restart drops the partial period instead of finishing it
  assign timeout = (state_r == PWT_ST_RUN) && !cfg_change && src_tick &&
                   (count_r == terminal - 16'h0001);

  // Count moves only in RUN and reads zero whenever the timer is off
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      count_r <= 16'h0000;
    end else if (state_r != PWT_ST_RUN || cfg_change) begin
      count_r <= 16'h0000;
    end else if (timeout) begin
      count_r <= 16'h0000;
    end else if (src_tick) begin
      count_r <= count_r + 16'h0001;
    end
  end

  // ==========================================================
  // Timeout flag
  // A timeout on the acknowledge edge is never lost
  // set on timeout, set wins over acknowledge
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      wakeup_timeout_flag_r <= 1'b0;
    end else if (timeout) begin
      wakeup_timeout_flag_r <= 1'b1;
    end else if (flag_clear) begin
      wakeup_timeout_flag_r <= 1'b0;
    end
  end

  // Combinational, so the request falls on the edge the flag clears
  // request while flag and enable
  assign wakeup_irq_out = wakeup_timeout_flag_r && wakeup_irq_enable_r;

  // ==========================================================
  // Sticky events, cleared by reading the status register
  // Overrun: a timeout while the previous one is still unacknowledged
  // It warns that software acknowledged too late and lost a period
  assign evt[EVT_TIMEOUT] = timeout;
  assign evt[EVT_OVERRUN] = timeout && wakeup_timeout_flag_r && !flag_clear;

  generate
    for (genvar i = 0; i < EVT_W; i++) begin : g_evt
      // New event beats the read that would clear it
      always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
          irq_status_r[i] <= 1'b0;
        end else if (evt[i]) begin
          irq_status_r[i] <= 1'b1;
        end else if (rd_irq) begin
          irq_status_r[i] <= 1'b0;
        end
      end
    end
  endgenerate

  assign irq_out = |(irq_status_r & irq_mask_r);

  // ==========================================================
  // Count snapshot
  // Reading the low byte freezes the high byte so the pair is coherent
  // Limitation: a high-byte read with no low-byte read returns an old snapshot
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      count_hold_r <= 16'h0000;
    end else if (reg_rd_in && (reg_addr_in == OFF_COUNT_LO)) begin
      count_hold_r <= count_r;
    end
  end

  // ==========================================================
  // Read data
  always_comb begin
    rdata_nxt = 8'h00;
    unique case (reg_addr_in)
      OFF_STATUS_CONTROL: begin
        // unused bits and acknowledge read 0
        rdata_nxt[BIT_TIMEOUT_FLAG] = wakeup_timeout_flag_r;
        rdata_nxt[BIT_CLOCK_SELECT] = wakeup_clock_select_r;
        rdata_nxt[BIT_IRQ_ENABLE] = wakeup_irq_enable_r;
        rdata_nxt[PSEL_MSB:PSEL_LSB] = wakeup_period_select_r;
      end
      OFF_IRQ_STATUS: begin
        // Cleared by this very read
        rdata_nxt[EVT_W-1:0] = irq_status_r;
      end
      OFF_IRQ_MASK: begin
        rdata_nxt[EVT_W-1:0] = irq_mask_r;
      end
      OFF_COUNT_LO: begin
        // Live low byte; the snapshot is taken on this read
        rdata_nxt = count_r[7:0];
      end
      OFF_COUNT_HI: begin
        // High byte from the snapshot
        rdata_nxt = count_hold_r[15:8];
      end
      default: begin
        // Unmapped offsets read zero
        rdata_nxt = 8'h00;
      end
    endcase
  end

  // Data stand only in the cycle after the read strobe
  // Zero outside that slot lets a parent or read buses together
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= 8'h00;
    end else if (reg_rd_in) begin
      rdata_r <= rdata_nxt;
    end else begin
      rdata_r <= 8'h00;
    end
  end

  assign reg_rdata_out = rdata_r;

endmodule

//--- dv/pwt_top_sva.sv
`timescale 1ns/1ns
// ==========
// Port checks for the wakeup timer
module pwt_top_sva
  import pwt_pkg::*;
#(
  parameter int unsigned OSC_CYCLES = pwt_pkg::OSC_CYCLES
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic arst_n_in,
  // Timer source and register port
  input wire logic ext_clk_in,
  input wire logic [pwt_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic [pwt_pkg::DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [pwt_pkg::DATA_W-1:0] reg_rdata_out,
  // Requests
  input wire logic wakeup_irq_out,
  input wire logic irq_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  // Write to the control register
  logic wr_ctl;
  assign wr_ctl = reg_wr_in && reg_addr_in == OFF_STATUS_CONTROL;

  property p_rd_idle;
    !$past(reg_rd_in) |-> reg_rdata_out == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
  property p_ctl_zero_bits;
    $past(reg_rd_in) && $past(reg_addr_in) == OFF_STATUS_CONTROL |-> !reg_rdata_out[6] && !reg_rdata_out[3];
  endproperty
  a_ctl_zero_bits: assert property (p_ctl_zero_bits) else $error("bit 6 or 3 reads one");
  property p_unmapped;
    $past(reg_rd_in) && $past(reg_addr_in) > OFF_COUNT_HI |-> reg_rdata_out == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_ack_clears;
    wr_ctl && reg_wdata_in[6] |=> !wakeup_irq_out;
  endproperty
  a_ack_clears: assert property (p_ack_clears) else $error("request kept after clear");
  property p_zero_ack_keeps;
    wr_ctl && !reg_wdata_in[6] && reg_wdata_in[4] && wakeup_irq_out |=> wakeup_irq_out;
  endproperty
  a_zero_ack_keeps: assert property (p_zero_ack_keeps) else $error("zero clear bit lost flag");
  property p_enable_blocks;
    wr_ctl && !reg_wdata_in[4] |=> !wakeup_irq_out;
  endproperty
  a_enable_blocks: assert property (p_enable_blocks) else $error("request while disabled");
  property p_flag_sticky;
    wakeup_irq_out && !wr_ctl |=> wakeup_irq_out;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("request dropped by itself");
  property p_code0_quiet;
    wr_ctl && reg_wdata_in[6] && reg_wdata_in[2:0] == 3'h0 |=> !wakeup_irq_out [*8];
  endproperty
  a_code0_quiet: assert property (p_code0_quiet) else $error("timeout with code zero");
  property p_status_read_clears;
    reg_rd_in && reg_addr_in == OFF_IRQ_STATUS |=> !irq_out;
  endproperty
  a_status_read_clears: assert property (p_status_read_clears) else $error("irq kept after status read");
endmodule

bind pwt_top pwt_top_sva #(.OSC_CYCLES(OSC_CYCLES)) u_sva (.clk_in(clk_in), .arst_n_in(arst_n_in),
  .ext_clk_in(ext_clk_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
  .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .wakeup_irq_out(wakeup_irq_out), .irq_out(irq_out));

//--- dv/tb.sv
`timescale 1ns/1ns
// ==========
// Register-level bench for the wakeup timer
module tb;
  import pwt_pkg::*;
  // Short oscillator so all internal codes fit in one run
  localparam int unsigned OSC = 4;
  localparam int TICKS [8] = '{0, 8, 32, 64, 128, 256, 512, 1024};
  localparam int DIVS [8] = '{0, 256, 1024, 2048, 4096, 8192, 16384, 32768};
  logic clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic ext_clk_in = 1'b0;
  logic ext_run = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic wirq;
  logic irq;
  int error_cnt = 0;
  int num_checks = 0;
  int cyc = 0;

  pwt_top #(.OSC_CYCLES(OSC)) uut (.clk_in(clk_in), .arst_n_in(arst_n_in), .ext_clk_in(ext_clk_in),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
    .wakeup_irq_out(wirq), .irq_out(irq));

  // ==========
  // Clock, external source and hang guard
  always #20 clk_in = ~clk_in;
  // One external rising edge per two clocks, still outside external runs
  always @(posedge clk_in) begin
    ext_clk_in <= ext_run & ~ext_clk_in;
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      error_cnt++;
      report_and_stop;
    end
  end

  // ==========
  // Tasks
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask
  // Read data is looked at mid-cycle, its only valid slot
  task automatic rd_reg(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    @(negedge clk_in);
    check(rdata, e);
  endtask
  // Start one period, time it, hold, clear, then stop the timer
  task automatic run_one(input logic sel, input int k);
    int t;
    int n;
    logic [7:0] cfg;
    cfg = {2'b00, sel, 1'b1, 1'b0, k[2:0]};
    t = sel ? 2 * DIVS[k] : OSC * TICKS[k];
    n = 0;
    ext_run = sel;
    wr_reg(OFF_STATUS_CONTROL, cfg);
    while (wirq !== 1'b1 && n < t + 40) begin
      @(negedge clk_in);
      n++;
    end
    check({7'h00, n >= t && n <= t + OSC + 8}, 8'h01);
    check({7'h00, irq}, 8'h01);
    wr_reg(OFF_STATUS_CONTROL, cfg);
    rd_reg(OFF_STATUS_CONTROL, cfg | 8'h80);
    wr_reg(OFF_STATUS_CONTROL, 8'h50);
    @(negedge clk_in);
    check({7'h00, wirq}, 8'h00);
    rd_reg(OFF_IRQ_STATUS, 8'h01);
    check({7'h00, irq}, 8'h00);
    ext_run = 1'b0;
  endtask
  task automatic report_and_stop;
    $display("mismatches %0d of %0d checks", error_cnt, num_checks);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ==========
  // Main sequence
  initial begin
    repeat (4) @(posedge clk_in);
    arst_n_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    rd_reg(OFF_STATUS_CONTROL, 8'h00);
    rd_reg(OFF_IRQ_MASK, 8'h00);
    // 1 ms at 40 ns is 25000 clocks, 250 hundreds
    check(8'(OSC_CYCLES / 100), 8'hFA);
    wr_reg(OFF_STATUS_CONTROL, 8'hF8);
    rd_reg(OFF_STATUS_CONTROL, 8'h30);
    wr_reg(4'hF, 8'hFF);
    rd_reg(4'hF, 8'h00);
    rd_reg(OFF_STATUS_CONTROL, 8'h30);
    // Code zero stays quiet on both sources, internal first
    wr_reg(OFF_STATUS_CONTROL, 8'h10);
    repeat (200) @(negedge clk_in);
    check({7'h00, wirq}, 8'h00);
    ext_run = 1'b1;
    wr_reg(OFF_STATUS_CONTROL, 8'h70);
    repeat (600) @(negedge clk_in);
    check({7'h00, wirq}, 8'h00);
    ext_run = 1'b0;
    // Enable off: flag sets, request stays low, masked irq stays low
    // Two timeouts pass unacknowledged, so overrun sets; count is 2 ticks on
    wr_reg(OFF_STATUS_CONTROL, 8'h01);
    repeat (75) @(negedge clk_in);
    check({6'h00, wirq, irq}, 8'h00);
    rd_reg(OFF_COUNT_LO, 8'h02);
    rd_reg(OFF_COUNT_HI, 8'h00);
    rd_reg(OFF_STATUS_CONTROL, 8'h81);
    wr_reg(OFF_IRQ_MASK, 8'h01);
    @(negedge clk_in);
    check({7'h00, irq}, 8'h01);
    wr_reg(OFF_STATUS_CONTROL, 8'h40);
    rd_reg(OFF_IRQ_STATUS, 8'h03);
    check({7'h00, irq}, 8'h00);
    for (int k = 1; k < 8; k++) begin
      run_one(1'b0, k);
    end
    for (int k = 1; k < 5; k++) begin
      run_one(1'b1, k);
    end
    report_and_stop;
  end
endmodule
